// ===== logic/afs_defs.vh
// afs_defs.vh: offsets, field positions and reset values of the audio fifo status port.
// assumes inclusion by bare name from the design files under logic/.
`ifndef AFS_DEFS_VH
`define AFS_DEFS_VH

// register offsets, byte addresses
`define AFS_OFS_CTRL 8'h00
`define AFS_OFS_IEN 8'h08
`define AFS_OFS_STATUS 8'h0C
`define AFS_OFS_TX 8'h10
`define AFS_OFS_RX 8'h14
`define AFS_OFS_CLR 8'h18

// control fields: fifo level settings
`define AFS_TXLVL_HI 2
`define AFS_TXLVL_LO 0
`define AFS_RXLVL_HI 6
`define AFS_RXLVL_LO 4

// status fields
`define AFS_TX_WORD_COUNT_HI 31
`define AFS_TX_WORD_COUNT_LO 28
`define AFS_RX_WORD_COUNT_HI 27
`define AFS_RX_WORD_COUNT_LO 24
`define AFS_B_LZC 23
`define AFS_B_RZC 22
`define AFS_B_TXBUSY 21
`define AFS_B_TXEMPTY 20
`define AFS_B_TX_FIFO_FULL 19
`define AFS_B_TX_LEVEL_SETTING 18
`define AFS_B_TXOV 17
`define AFS_B_TXUD 16
`define AFS_B_RX_FIFO_EMPTY 12
`define AFS_B_RX_FIFO_FULL 11
`define AFS_B_RX_LEVEL_SETTING 10
`define AFS_B_RXOV 9
`define AFS_B_RXUD 8
`define AFS_B_RIGHT 3
`define AFS_B_TX_IRQ_SUMMARY 2
`define AFS_B_RX_IRQ_SUMMARY 1
`define AFS_B_AIF 0

// interrupt enable fields
`define AFS_E_LZC 12
`define AFS_E_RZC 11
`define AFS_E_TX_LEVEL_SETTING 10
`define AFS_E_TXOV 9
`define AFS_E_TXUD 8
`define AFS_E_RX_LEVEL_SETTING 2
`define AFS_E_RXOV 1
`define AFS_E_RXUD 0

// reset values
`define AFS_RST_WORD 32'h0000_0000
`define AFS_RST_LEVEL 3'h0
// pins at rest: bit clock high, frame select and data low, so no false edge follows reset
`define AFS_RST_PINS 3'h4

`endif

// ===== logic/afs_fifo.v
// afs_fifo.v: first-in first-out word store with count, full and empty.
// assumes push and pop come from logic on the same clock.
`timescale 1ns/1ns
module afs_fifo
#(
  parameter W = 32,
  parameter DEPTH = 8,
  parameter AW = 3
)
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // filling side
  input wire push,
  input wire [W-1:0] pushData,
  // draining side
  input wire pop,
  output wire [W-1:0] popData,
  // state
  output wire [AW:0] count,
  output wire full,
  output wire empty
);

  reg [W-1:0] mem [0:DEPTH-1]; // word storage
  reg [AW-1:0] wrPtr; // next slot to write
  reg [AW-1:0] rdPtr; // oldest word
  reg [AW:0] fill; // words held

  // a push when full and a pop when empty change nothing
  wire doPush = push && !full;
  wire doPop = pop && !empty;

  assign full = (fill == DEPTH[AW:0]);
  assign empty = (fill == {(AW+1){1'b0}});
  assign count = fill;
  // oldest word; undefined content when empty
  assign popData = mem[rdPtr];

  // storage write, no reset needed
  always @(posedge mclk)
  begin
    if (doPush)
    begin
      mem[wrPtr] <= pushData;
    end
  end

  // pointers and fill level
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doPush)
      begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (doPop)
      begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (doPush && !doPop)
      begin
        fill <= fill + 1'b1;
      end
      else if (doPop && !doPush)
      begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule

// ===== logic/afs_fifo_status_port.v
// afs_fifo_status_port.v: sample fifos, status flags and interrupts of an audio serial port.
// assumes a plain register port on mclk and an external codec driving bit clock and frame select.
// Behaviour
// R1: tx full bit follows fifo full
// R2: tx level flag while count at or below setting
// R3: push into full tx sets sticky overflow
// R4: sample needed from empty tx sets underflow
// R5: rx empty bit follows fifo empty
// R6: rx full bit follows fifo full
// R7: rx level flag while count at or above setting
// R8: sample into full rx lost, sets overflow
// R9: read of empty rx sets sticky underflow
// R10: channel bit high for right channel
// R11: tx summary from enabled tx and zero-cross flags
// R12: rx summary from enabled rx flags
// R13: overall summary and interrupt output on any
// R14: writes to tx port push eight-deep fifo
// R15: reads of rx port pop eight-deep fifo
// R16: tx and rx counts in status top bits
// R17: each flag gated by its own enable
// R18: full push, empty pop leave fifo unchanged
`timescale 1ns/1ns
`include "afs_defs.vh"
module afs_fifo_status_port
#(
  parameter SAMPLE_W = 16,
  parameter DEPTH = 8,
  parameter AW = 3
)
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // register port
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  // serial link pins
  input wire bitClk,
  input wire lrClk,
  input wire serIn,
  output reg serOut,
  // interrupt
  output reg irq
);

  // register decode
  wire wrCtrl = regWr && (regAddr == `AFS_OFS_CTRL);
  wire wrIen = regWr && (regAddr == `AFS_OFS_IEN);
  wire wrStatus = regWr && (regAddr == `AFS_OFS_STATUS);
  wire wrClr = regWr && (regAddr == `AFS_OFS_CLR);
  wire wrTx = regWr && (regAddr == `AFS_OFS_TX);
  wire rdRx = regRd && (regAddr == `AFS_OFS_RX);
  // ones written to status or clear register drop sticky flags
  wire [31:0] clrMask = (wrStatus || wrClr) ? regWdata : `AFS_RST_WORD;

  // software settings
  reg [2:0] txLevelSetting; // tx level threshold
  reg [2:0] rxLevelSetting; // rx level threshold
  reg [31:0] ienReg; // interrupt enables

  // sticky flags
  reg txOverflowFlag;
  reg txUnderflowFlag;
  reg rxOverflowFlag;
  reg rxUnderflowFlag;
  reg leftZeroCrossFlag;
  reg rightZeroCrossFlag;

  // pin synchronisers: bit 2 bit clock, bit 1 frame select, bit 0 data
  reg [2:0] pinA; // first stage, read only by pinB
  reg [2:0] pinB;
  reg [2:0] pinC;
  reg [2:0] pinLvl; // accepted levels
  reg [2:0] pinPrev; // accepted levels one cycle back

  // serial engine state
  reg lrLast; // frame select at last boundary
  reg started; // a first frame boundary has passed; rx pushes start at the next one
  reg rightCh; // channel now shifting
  reg txBusy; // a word is in the tx shifter
  reg signLeft; // last left sample sign
  reg signRight; // last right sample sign
  reg primeLeft; // left sign valid
  reg primeRight; // right sign valid
  reg [SAMPLE_W-1:0] txShift; // outgoing bits
  reg [SAMPLE_W-1:0] rxShift; // incoming bits

  // fifo connections
  wire [31:0] txHead;
  wire [31:0] rxHead;
  wire [AW:0] txWordCount;
  wire [AW:0] rxWordCount;
  wire txFifoFull;
  wire txFifoEmpty;
  wire rxFifoFull;
  wire rxFifoEmpty;

  // edges of the accepted bit clock and frame select
  wire bclkRise = pinLvl[2] && !pinPrev[2];
  wire bclkFall = !pinLvl[2] && pinPrev[2];
  wire boundary = bclkFall && (pinLvl[1] != lrLast);
  wire txPop = boundary && !txFifoEmpty;
  wire rxPush = boundary && started;
  wire newSign = txHead[SAMPLE_W-1];

  // hardware events
  wire txOvEvent = wrTx && txFifoFull; // [R3]
  wire txUdEvent = boundary && txFifoEmpty; // [R4]
  wire rxOvEvent = rxPush && rxFifoFull; // [R8]
  wire rxUdEvent = rdRx && rxFifoEmpty; // [R9]
  wire lzcEvent = txPop && !pinLvl[1] && primeLeft && (newSign != signLeft);
  wire rzcEvent = txPop && pinLvl[1] && primeRight && (newSign != signRight);

  // level flags from counts
  wire txLevelFlag = (txWordCount <= {1'b0, txLevelSetting}); // [R2]
  wire rxLevelFlag = (rxWordCount >= {1'b0, rxLevelSetting}); // [R7]

  // interrupt summaries, each flag gated by its enable
  wire txIrqSummary = (txOverflowFlag && ienReg[`AFS_E_TXOV]) // [R17]
    || (txUnderflowFlag && ienReg[`AFS_E_TXUD])
    || (txLevelFlag && ienReg[`AFS_E_TX_LEVEL_SETTING])
    || (leftZeroCrossFlag && ienReg[`AFS_E_LZC])
    || (rightZeroCrossFlag && ienReg[`AFS_E_RZC]); // [R11]
  wire rxIrqSummary = (rxOverflowFlag && ienReg[`AFS_E_RXOV])
    || (rxUnderflowFlag && ienReg[`AFS_E_RXUD])
    || (rxLevelFlag && ienReg[`AFS_E_RX_LEVEL_SETTING]); // [R12]
  wire audioIrqSummary = txIrqSummary || rxIrqSummary; // [R13]

  // status word assembly
  reg [31:0] statusWord;
  always @*
  begin
    statusWord = `AFS_RST_WORD;
    statusWord[`AFS_TX_WORD_COUNT_HI:`AFS_TX_WORD_COUNT_LO] = txWordCount; // [R16]
    statusWord[`AFS_RX_WORD_COUNT_HI:`AFS_RX_WORD_COUNT_LO] = rxWordCount; // [R16]
    statusWord[`AFS_B_LZC] = leftZeroCrossFlag;
    statusWord[`AFS_B_RZC] = rightZeroCrossFlag;
    statusWord[`AFS_B_TXBUSY] = txBusy;
    statusWord[`AFS_B_TXEMPTY] = txFifoEmpty;
    statusWord[`AFS_B_TX_FIFO_FULL] = txFifoFull; // [R1]
    statusWord[`AFS_B_TX_LEVEL_SETTING] = txLevelFlag;
    statusWord[`AFS_B_TXOV] = txOverflowFlag;
    statusWord[`AFS_B_TXUD] = txUnderflowFlag;
    statusWord[`AFS_B_RX_FIFO_EMPTY] = rxFifoEmpty; // [R5]
    statusWord[`AFS_B_RX_FIFO_FULL] = rxFifoFull; // [R6]
    statusWord[`AFS_B_RX_LEVEL_SETTING] = rxLevelFlag;
    statusWord[`AFS_B_RXOV] = rxOverflowFlag;
    statusWord[`AFS_B_RXUD] = rxUnderflowFlag;
    statusWord[`AFS_B_RIGHT] = rightCh; // [R10]
    statusWord[`AFS_B_TX_IRQ_SUMMARY] = txIrqSummary;
    statusWord[`AFS_B_RX_IRQ_SUMMARY] = rxIrqSummary;
    statusWord[`AFS_B_AIF] = audioIrqSummary;
  end

  // transmit fifo, filled by software writes
  afs_fifo #(.W(32), .DEPTH(DEPTH), .AW(AW)) txFifo
  (
    .mclk(mclk),
    .rst(rst),
    .push(wrTx), // [R14] [R18]
    .pushData(regWdata),
    .pop(txPop),
    .popData(txHead),
    .count(txWordCount),
    .full(txFifoFull),
    .empty(txFifoEmpty)
  );

  // receive fifo, filled by the serial engine
  afs_fifo #(.W(32), .DEPTH(DEPTH), .AW(AW)) rxFifo
  (
    .mclk(mclk),
    .rst(rst),
    .push(rxPush),
    .pushData({{(32-SAMPLE_W){1'b0}}, rxShift}),
    .pop(rdRx), // [R15] [R18]
    .popData(rxHead),
    .count(rxWordCount),
    .full(rxFifoFull),
    .empty(rxFifoEmpty)
  );

  // settings registers
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      txLevelSetting <= `AFS_RST_LEVEL;
      rxLevelSetting <= `AFS_RST_LEVEL;
      ienReg <= `AFS_RST_WORD;
    end
    else
    begin
      if (wrCtrl)
      begin
        txLevelSetting <= regWdata[`AFS_TXLVL_HI:`AFS_TXLVL_LO];
        rxLevelSetting <= regWdata[`AFS_RXLVL_HI:`AFS_RXLVL_LO];
      end
      if (wrIen)
      begin
        ienReg <= regWdata;
      end
    end
  end

  // sticky flags: an event in the clearing cycle keeps the flag set
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      txOverflowFlag <= 1'b0;
      txUnderflowFlag <= 1'b0;
      rxOverflowFlag <= 1'b0;
      rxUnderflowFlag <= 1'b0;
      leftZeroCrossFlag <= 1'b0;
      rightZeroCrossFlag <= 1'b0;
    end
    else
    begin
      txOverflowFlag <= txOvEvent || (txOverflowFlag && !clrMask[`AFS_B_TXOV]); // [R3]
      txUnderflowFlag <= txUdEvent || (txUnderflowFlag && !clrMask[`AFS_B_TXUD]); // [R4]
      rxOverflowFlag <= rxOvEvent || (rxOverflowFlag && !clrMask[`AFS_B_RXOV]); // [R8]
      rxUnderflowFlag <= rxUdEvent || (rxUnderflowFlag && !clrMask[`AFS_B_RXUD]); // [R9]
      leftZeroCrossFlag <= lzcEvent || (leftZeroCrossFlag && !clrMask[`AFS_B_LZC]);
      rightZeroCrossFlag <= rzcEvent || (rightZeroCrossFlag && !clrMask[`AFS_B_RZC]);
    end
  end

  // read data stands only in the cycle after the read strobe
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      regRdata <= `AFS_RST_WORD;
    end
    else if (regRd)
    begin
      case (regAddr)
        `AFS_OFS_CTRL:
        begin
          regRdata <= {25'h000_0000, rxLevelSetting, 1'b0, txLevelSetting};
        end
        `AFS_OFS_IEN:
        begin
          regRdata <= ienReg;
        end
        `AFS_OFS_STATUS:
        begin
          regRdata <= statusWord;
        end
        `AFS_OFS_RX:
        begin
          regRdata <= rxHead; // [R15]
        end
        default:
        begin
          regRdata <= `AFS_RST_WORD; // unmapped and write-only read as zero
        end
      endcase
    end
    else
    begin
      regRdata <= `AFS_RST_WORD;
    end
  end

  // interrupt output, registered
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= audioIrqSummary; // [R13]
    end
  end

  // three-stage pin sampling; a change is taken once stages two and three agree
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pinA <= `AFS_RST_PINS;
      pinB <= `AFS_RST_PINS;
      pinC <= `AFS_RST_PINS;
      pinLvl <= `AFS_RST_PINS;
      pinPrev <= `AFS_RST_PINS;
    end
    else
    begin
      pinA <= {bitClk, lrClk, serIn};
      pinB <= pinA;
      pinC <= pinB;
      pinLvl <= (pinC & ~(pinB ^ pinC)) | (pinLvl & (pinB ^ pinC));
      pinPrev <= pinLvl;
    end
  end

  // serial engine: sample in on rising bit clock, shift out on falling
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lrLast <= 1'b0;
      started <= 1'b0;
      rightCh <= 1'b0;
      txBusy <= 1'b0;
      signLeft <= 1'b0;
      signRight <= 1'b0;
      primeLeft <= 1'b0;
      primeRight <= 1'b0;
      txShift <= {SAMPLE_W{1'b0}};
      rxShift <= {SAMPLE_W{1'b0}};
      serOut <= 1'b0;
    end
    else
    begin
      if (bclkRise)
      begin
        rxShift <= {rxShift[SAMPLE_W-2:0], pinLvl[0]};
      end
      if (boundary)
      begin
        // frame select moved: a new word starts
        lrLast <= pinLvl[1];
        started <= 1'b1;
        rightCh <= pinLvl[1]; // [R10]
        txBusy <= !txFifoEmpty;
        if (txFifoEmpty)
        begin
          // nothing to send, zeros go out
          txShift <= {SAMPLE_W{1'b0}};
          serOut <= 1'b0;
        end
        else
        begin
          txShift <= txHead[SAMPLE_W-1:0];
          serOut <= newSign;
          if (pinLvl[1])
          begin
            signRight <= newSign;
            primeRight <= 1'b1;
          end
          else
          begin
            signLeft <= newSign;
            primeLeft <= 1'b1;
          end
        end
      end
      else if (bclkFall)
      begin
        // next bit, most significant first
        txShift <= {txShift[SAMPLE_W-2:0], 1'b0};
        serOut <= txShift[SAMPLE_W-2];
      end
    end
  end

endmodule

// ===== tb/afs_codec_model.sv
// afs_codec_model.sv: behavioural codec on the far side of the serial link.
// assumes the port samples its pins with mclk; bit clock stands high between slots.
`timescale 1ns/1ns
module afs_codec_model
(
  // slot request
  input wire [7:0] want,
  input wire [15:0] word,
  // serial pins
  input wire serOut,
  output reg bitClk,
  output reg lrClk,
  output reg serIn,
  // what was heard and how many slots ran
  output reg [15:0] heard,
  output reg [7:0] slots
);
  integer i; // bit index
  reg [15:0] sh; // incoming tx bits
  reg [15:0] w; // word of this slot, differs per slot
  // one slot per pass: frame select moves, then 16 bits of 800 ns
  initial
  begin
    bitClk = 1'b1;
    lrClk = 1'b0;
    serIn = 1'b0;
    heard = 16'h0000;
    slots = 8'h00;
    sh = 16'h0000;
    forever
    begin
      wait (slots < want);
      w = word + {8'h00, slots};
      #1030 lrClk = ~lrClk; // next channel slot
      #200;
      for (i = 15; i >= 0; i = i - 1)
      begin
        bitClk = 1'b0;
        serIn = w[i]; // msb first, changed on the fall
        #400 bitClk = 1'b1;
        #200 sh = {sh[14:0], serOut}; // tx bit well settled
        #200;
      end
      serIn = ~serIn; // released line shows no stale value
      heard = sh;
      slots = slots + 8'h01;
    end
  end
endmodule

// ===== tb/afs_port_asserts.sv
// afs_port_asserts.sv: port checks of the audio fifo status port.
// assumes afs_defs.vh on the include path; bound to every instance of the port.
`timescale 1ns/1ns
`include "afs_defs.vh"
module afs_port_asserts
#(
  parameter SAMPLE_W = 16,
  parameter DEPTH = 8,
  parameter AW = 3
)
(
  // clock and reset
  input wire mclk,
  input wire rst,
  // register port
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdata,
  // serial link and interrupt
  input wire bitClk,
  input wire lrClk,
  input wire serIn,
  input wire serOut,
  input wire irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // a status read; its data stand in the next cycle only
  wire stRd = regRd && regAddr == `AFS_OFS_STATUS;
  tx_port_zero_a: assert property (regRd && regAddr == `AFS_OFS_TX |=> regRdata == 32'h0000_0000)
    else $error("tx port read not zero");
  irq_follows_bit_a: assert property (stRd ##1 regRdata[0] |-> ##[0:1] irq)
    else $error("irq missing while overall bit set");
  summary_or_a: assert property (stRd |=> regRdata[0] == (regRdata[1] | regRdata[2]))
    else $error("overall bit differs from summaries");
  tx_full_count_a: assert property (stRd |=> regRdata[19] == (regRdata[31:28] == 4'(DEPTH)))
    else $error("tx full bit differs from count");
  rx_empty_count_a: assert property (stRd |=> regRdata[12] == (regRdata[27:24] == 4'h0))
    else $error("rx empty bit differs from count");
  rx_full_count_a: assert property (stRd |=> regRdata[11] == (regRdata[27:24] == 4'(DEPTH)))
    else $error("rx full bit differs from count");
  count_bound_a: assert property (stRd |=> regRdata[31:28] <= 4'(DEPTH) && regRdata[27:24] <= 4'(DEPTH))
    else $error("fifo count beyond depth");
  // serial out moves five edges after the pin fall is first sampled, one less if the sampling races the pin
  serout_hold_a: assert property ($changed(serOut) |-> ($past(bitClk, 6) && !$past(bitClk, 5))
    || ($past(bitClk, 5) && !$past(bitClk, 4)))
    else $error("serial out moved without a bit clock fall");
  // main scenarios reached
  cover property (irq);
  cover property (stRd ##1 regRdata[9]);
  cover property ($fell(bitClk));
endmodule

bind afs_fifo_status_port afs_port_asserts #(.SAMPLE_W(SAMPLE_W), .DEPTH(DEPTH), .AW(AW)) chkPort
(
  .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .bitClk(bitClk), .lrClk(lrClk), .serIn(serIn), .serOut(serOut), .irq(irq)
);

// ===== tb/testbench.sv
// testbench.sv: register level tests of the audio fifo status port with a codec model.
// assumes afs_defs.vh on the include path and the checker bound from its own file.
`timescale 1ns/1ns
`include "afs_defs.vh"
module testbench;
  // clock, reset and register port
  reg mclk;
  reg rst;
  reg [7:0] regAddr;
  reg [31:0] regWdata;
  reg regWr;
  reg regRd;
  wire [31:0] regRdata;
  // serial link and interrupt
  wire bitClk, lrClk, serIn, serOut, irq;
  reg [7:0] want;
  wire [15:0] heard;
  wire [7:0] slots;
  integer miscompares, comparisons, cycles, k;
  reg [31:0] s, v;

  afs_fifo_status_port #(.SAMPLE_W(16), .DEPTH(8), .AW(3)) dut
  (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .bitClk(bitClk), .lrClk(lrClk), .serIn(serIn), .serOut(serOut), .irq(irq)
  );
  afs_codec_model codec
  (
    .want(want), .word(16'hA5C3), .serOut(serOut), .bitClk(bitClk), .lrClk(lrClk), .serIn(serIn),
    .heard(heard), .slots(slots)
  );

  // 10 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      miscompares = miscompares + 1;
      final_report;
    end
  end

  // one-cycle write strobe
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  end
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task rd(input [7:0] a, output [31:0] d);
  begin
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  end
  endtask

  // compare and count
  task chk(input string n, input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  end
  endtask

  // counts, verdict and end of run
  task final_report;
  begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
    want = 8'h00;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(`AFS_OFS_STATUS, s);
    chk("status after reset", s, 32'h0014_1400);
    wr(`AFS_OFS_CTRL, 32'h0000_0032);
    // fill the tx fifo one past full
    for (k = 1; k <= 9; k = k + 1)
    begin
      // word 5 has its sign clear, a right channel zero cross against word 3
      wr(`AFS_OFS_TX, (k == 5) ? 32'h0000_0005 : 32'h0001_8000 | k);
      rd(`AFS_OFS_STATUS, s);
      chk("tx count", s[31:28], (k > 8) ? 8 : k);
      chk("tx full", s[19], k >= 8);
      chk("tx level", s[18], k <= 2);
      chk("tx overflow", s[17], k == 9);
    end
    rd(8'h40, v);
    chk("unmapped read", v, 32'h0000_0000);
    rd(`AFS_OFS_TX, v);
    chk("tx port read", v, 32'h0000_0000);
    // overflow interrupt: raised, masked, cleared
    wr(`AFS_OFS_IEN, 32'h0000_0200);
    rd(`AFS_OFS_STATUS, s);
    chk("tx summary", s[2:0], 3'h5);
    chk("irq raised", irq, 1'b1);
    wr(`AFS_OFS_IEN, 32'h0000_0000);
    rd(`AFS_OFS_STATUS, s);
    chk("masked", {s[17], s[2:0], irq}, 5'h10);
    wr(`AFS_OFS_IEN, 32'h0000_0200);
    wr(`AFS_OFS_STATUS, 32'h0002_0000);
    rd(`AFS_OFS_STATUS, s);
    chk("overflow cleared", {s[17], s[2:0], irq}, 5'h00);
    // rx underflow through an empty pop
    wr(`AFS_OFS_IEN, 32'h0000_0001);
    rd(`AFS_OFS_RX, v);
    rd(`AFS_OFS_STATUS, s);
    chk("rx underflow", {s[27:24], s[8], s[2:0]}, 8'h0B);
    wr(`AFS_OFS_CLR, 32'h0000_0100);
    wr(`AFS_OFS_IEN, 32'h0000_0000);
    rd(`AFS_OFS_STATUS, s);
    chk("underflow cleared", s[8], 1'b0);
    // ten codec slots: tx drains then underflows, rx fills then overflows
    want <= 8'h0A;
    for (k = 1; k <= 10; k = k + 1)
    begin
      wait (slots == k);
      rd(`AFS_OFS_STATUS, s);
      if (k <= 8)
        chk("heard", heard, (k == 5) ? 16'h0005 : 16'h8000 | k);
      chk("zero cross", s[23:22], {1'b0, k >= 5});
      chk("right", s[3], k % 2);
      chk("tx count", s[31:28], (k < 8) ? 8 - k : 0);
      chk("tx underflow", s[16], k >= 9);
      chk("tx level", s[18], k >= 6);
      chk("rx count", s[27:24], (k > 8) ? 8 : k - 1);
      chk("rx flags", s[12:8], {k == 1, k >= 9, k >= 4, k >= 10, 1'b0});
    end
    // drain rx in arrival order
    for (k = 0; k <= 7; k = k + 1)
    begin
      rd(`AFS_OFS_RX, v);
      chk("rx word", v, 32'h0000_A5C3 + k);
      rd(`AFS_OFS_STATUS, s);
      chk("rx count", s[27:24], 7 - k);
      chk("rx level", s[10], (7 - k) >= 3);
    end
    // right zero cross feeds the tx summary once enabled, and drops with its flag
    wr(`AFS_OFS_IEN, 32'h0000_0800);
    rd(`AFS_OFS_STATUS, s);
    chk("zero cross summary", {s[23:22], s[2:0]}, 5'h0D);
    wr(`AFS_OFS_CLR, 32'h0040_0000);
    rd(`AFS_OFS_STATUS, s);
    chk("zero cross cleared", {s[22], s[2:0], irq}, 5'h00);
    final_report;
  end
endmodule
